// >>> src/ipwc_top.sv
// interrupt arbitration, vectoring, nesting and stop/idle wake-up
// assumes the core pulses irq_ack when it jumps to irq_vector and ret_done at return
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module ipwc_top
    import ipwc_pkg::*;
#(
    parameter int EXT_HS_WAIT = EXT_HS_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NSRC-1:0] src_event,
    input wire logic [7:0] port0_in,
    input wire logic [7:0] port1_in,
    input wire logic osc_is_ext,
    input wire logic ls_clk_in,
    output logic core_run,
    input wire logic irq_ack,
    input wire logic ret_done,
    output logic irq_take,
    output logic [15:0] irq_vector
);
    ipwc_state_t s_r;
    ipwc_state_t s_nxt;
    logic [NSRC-1:0] req;
    logic [1:0] glvl [NGRP];
    logic [1:0] slvl [NSRC];

    ////////////////////////////////////////////////////////////////////////////
    // per-source level and request qualification
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            assign slvl[gi] = glvl[GRP[gi]];
            assign req[gi] = s_r.flag[gi] & s_r.en[ENP[gi]] & s_r.en[GIE_BIT];
        end
        for (gi = 0; gi < NGRP; gi++) begin : g_grp
            assign glvl[gi] = {s_r.lvl_hi[gi], s_r.lvl_lo[gi]};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic [1:0] best_lvl;
        int best;
        logic found;
        logic wake;
        logic [7:0] pchg;
        logic [3:0] top;
        logic ls_rise;
        logic [15:0] wmask;
        s_nxt = s_r;
        best_lvl = LVL_NONE;
        best = 0;
        found = 1'b0;
        top = 4'h0;
        wake = 1'b0;
        pchg = 8'h00;
        ls_rise = 1'b0;
        wmask = 16'h0000;
        s_nxt.take = 1'b0;
        s_nxt.p0_prev = port0_in;
        s_nxt.p1_prev = port1_in;
        s_nxt.ls_prev = ls_clk_in;
        ls_rise = ls_clk_in & ~s_r.ls_prev;
        // events set flags regardless of enables; set wins over clear below
        wmask = 16'h0000;
        if (reg_wr && reg_addr == OFS_FLAG_LO) begin
            wmask[7:0] = ~reg_wdata;
        end
        if (reg_wr && reg_addr == OFS_FLAG_HI) begin
            wmask[14:8] = ~reg_wdata[6:0];
        end
        s_nxt.flag = (s_r.flag & ~wmask) | {1'b0, src_event};
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_P1_WAKE: s_nxt.p1_wake = reg_wdata;
                OFS_LVL_LO: s_nxt.lvl_lo = {2'b00, reg_wdata[5:0]};
                OFS_LVL_HI: s_nxt.lvl_hi = {2'b00, reg_wdata[5:0]};
                OFS_IRQ_EN0: s_nxt.en[7:0] = reg_wdata & 8'hBF;
                OFS_IRQ_EN1: s_nxt.en[15:8] = reg_wdata & 8'h3F;
                OFS_IRQ_EN2: s_nxt.en[23:16] = reg_wdata & 8'h0D;
                OFS_PWR_CTRL: begin
                    s_nxt.stop = reg_wdata[1];
                    s_nxt.idle = reg_wdata[0];
                end
                default: ;
            endcase
        end
        // arbitration: highest level, then lowest index (default order)
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i] && (!found || slvl[i] >= best_lvl)) begin
                found = 1'b1;
                best_lvl = slvl[i];
                best = i;
            end
        end
        // highest active level: priority encode active bitmap
        for (int l = 0; l < 4; l++) begin
            if (s_r.active[l]) begin
                top = 4'h0;
                top[l] = 1'b1;
            end
        end
        // a new request must beat every running level; only one offer is open until the core acknowledges
        if (found && s_r.run && !s_r.pend && !irq_ack) begin
            if (s_r.active == 4'h0 || (top < (4'h1 << best_lvl))) begin
                s_nxt.take = 1'b1;
                s_nxt.pend = 1'b1;
                s_nxt.sel = 4'(best);
                s_nxt.vector = VEC[best];
            end
        end
        // core jumps: the offered source goes active, not whoever wins now
        if (irq_ack && s_r.pend) begin
            s_nxt.pend = 1'b0;
            s_nxt.active[slvl[s_r.sel]] = 1'b1;
            if (!SW_CLR[s_r.sel] && !src_event[s_r.sel] && s_r.en[ENP[s_r.sel]]) begin
                s_nxt.flag[s_r.sel] = 1'b0;
            end
        end else if (ret_done) begin
            s_nxt.active = s_r.active & ~top;
        end
        // wake-up detection
        pchg = (port0_in ^ s_r.p0_prev) | ((port1_in ^ s_r.p1_prev) & s_r.p1_wake);
        wake = (|pchg) || (|req);
        unique case (s_r.wst)
            IPWC_RUN: begin
                s_nxt.run = ~(s_nxt.stop | s_nxt.idle);
                if ((s_r.stop || s_r.idle) && wake) begin
                    s_nxt.stop = 1'b0;
                    s_nxt.idle = 1'b0;
                    if (s_r.stop) begin
                        s_nxt.wst = IPWC_HOLD_HS;
                        s_nxt.hs_cnt = osc_is_ext ? 12'(EXT_HS_WAIT - 1) : 12'(IRC_HS_CYC - 1);
                        s_nxt.ls_cnt = 3'(LS_CYC);
                        s_nxt.run = 1'b0;
                    end else begin
                        s_nxt.run = 1'b1;
                    end
                end
            end
            IPWC_HOLD_HS: begin
                if (s_r.hs_cnt == 12'h000) begin
                    s_nxt.wst = IPWC_HOLD_LS;
                end else begin
                    s_nxt.hs_cnt = s_r.hs_cnt - 12'h001;
                end
            end
            IPWC_HOLD_LS: begin
                if (ls_rise) begin
                    s_nxt.ls_cnt = s_r.ls_cnt - 3'h1;
                    if (s_r.ls_cnt == 3'h1) begin
                        s_nxt.wst = IPWC_RUN;
                        s_nxt.run = 1'b1;
                    end
                end
            end
            // unused state code: fall back to running rather than lock up
            default: begin
                s_nxt.wst = IPWC_RUN;
                s_nxt.run = 1'b1;
            end
        endcase
        // read data, one cycle later
        s_nxt.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_P1_WAKE: s_nxt.rdata = s_r.p1_wake;
                OFS_LVL_LO: s_nxt.rdata = s_r.lvl_lo;
                OFS_LVL_HI: s_nxt.rdata = s_r.lvl_hi;
                OFS_IRQ_EN0: s_nxt.rdata = s_r.en[7:0];
                OFS_IRQ_EN1: s_nxt.rdata = s_r.en[15:8];
                OFS_IRQ_EN2: s_nxt.rdata = s_r.en[23:16];
                OFS_FLAG_LO: s_nxt.rdata = s_r.flag[7:0];
                OFS_FLAG_HI: s_nxt.rdata = s_r.flag[15:8];
                OFS_PWR_CTRL: s_nxt.rdata = {6'h00, s_r.stop, s_r.idle};
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.run <= 1'b1;
            s_r.wst <= IPWC_RUN;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign core_run = s_r.run;
    assign irq_take = s_r.take;
    assign irq_vector = s_r.vector;
endmodule

// >>> src/ipwc_pkg.sv
// package for the interrupt priority and wake-up controller
// assumes a single 250 MHz system clock and a byte-wide register port
package ipwc_pkg;
    localparam int NSRC = 15;
    localparam int NGRP = 6;
    // register offsets (8-bit address space)
    localparam logic [7:0] OFS_P1_WAKE = 8'h91;
    localparam logic [7:0] OFS_LVL_LO = 8'hA9;
    localparam logic [7:0] OFS_LVL_HI = 8'hB9;
    localparam logic [7:0] OFS_IRQ_EN0 = 8'hA8;
    localparam logic [7:0] OFS_IRQ_EN1 = 8'hB8;
    localparam logic [7:0] OFS_IRQ_EN2 = 8'h9A;
    localparam logic [7:0] OFS_FLAG_LO = 8'hE0;
    localparam logic [7:0] OFS_FLAG_HI = 8'hE1;
    localparam logic [7:0] OFS_PWR_CTRL = 8'h87;
    localparam int GIE_BIT = 7;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_SRC = 16'h0000;
    // wake-up settling counts
    localparam int EXT_HS_CYC = 2048;
    localparam int IRC_HS_CYC = 64;
    localparam int LS_CYC = 5;
    localparam logic [1:0] LVL_NONE = 2'h0;
    // sources in default priority order, index 0 first
    localparam logic [15:0] VEC [NSRC] = '{16'h0003, 16'h0083, 16'h0043, 16'h000B, 16'h008B,
        16'h004B, 16'h0013, 16'h0093, 16'h0053, 16'h001B, 16'h005B, 16'h0023, 16'h0063,
        16'h002B, 16'h006B};
    localparam int GRP [NSRC] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 4, 4, 5, 5};
    // firmware-cleared sources: two-wire, serial-peripheral, uart
    localparam logic [15:0] SW_CLR = 16'h0824;
    // bit position of each source's enable in the packed 24-bit enable word
    localparam int ENP [NSRC] = '{0, 18, 8, 1, 16, 9, 2, 19, 10, 3, 11, 4, 12, 5, 13};
    typedef enum logic [1:0] {IPWC_RUN, IPWC_HOLD_HS, IPWC_HOLD_LS} ipwc_wake_t;
    typedef struct packed {
        logic [7:0] p1_wake;
        logic [7:0] lvl_lo;
        logic [7:0] lvl_hi;
        logic [23:0] en;
        logic [15:0] flag;
        logic stop;
        logic idle;
        ipwc_wake_t wst;
        logic [11:0] hs_cnt;
        logic [2:0] ls_cnt;
        logic ls_prev;
        logic [7:0] p0_prev;
        logic [7:0] p1_prev;
        logic [3:0] active;
        logic take;
        logic pend;
        logic [3:0] sel;
        logic [15:0] vector;
        logic [7:0] rdata;
        logic run;
    } ipwc_state_t;
endpackage

// >>> tb/ipwc_props.sv
// port checker for the interrupt controller
// assumes sync active-high rst on sys_clk; bound from the bench
`timescale 1ns/100ps
module ipwc_props
    import ipwc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic irq_ack,
    input wire logic irq_take,
    input wire logic [15:0] irq_vector,
    input wire logic core_run
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // read port: data only right after a read, reserved places read zero
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rdata without read");
    unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    lvl_reserved_a: assert property ($past(reg_rd) && ($past(reg_addr) == OFS_LVL_LO ||
        $past(reg_addr) == OFS_LVL_HI) |-> reg_rdata[7:6] == 2'b00) else $error("level reserved bits set");
    // take handshake: single pulses, none while the core acknowledges
    take_single_a: assert property (irq_take |=> !irq_take) else $error("take longer than one cycle");
    ack_blocks_a: assert property (irq_ack |=> !irq_take) else $error("take reissued during ack");
    vector_form_a: assert property (irq_take |-> (irq_vector & 16'hFF07) == 16'h0003) else $error("bad vector");
    vector_stable_a: assert property (!irq_take |-> $stable(irq_vector)) else $error("vector moved");
    // reset leaves the core running with no request
    reset_state_a: assert property (disable iff (1'b0) rst |=> core_run && !irq_take) else $error("reset state");
endmodule

// >>> tb/ipwc_core_model.sv
// core stand-in: acknowledges each take after a chosen delay, returns on command
// assumes takes are one-cycle pulses; a late ack must not meet a new winner
`timescale 1ns/100ps
module ipwc_core_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic irq_take,
    input wire logic ret_req,
    input wire logic [1:0] ack_dly,
    output logic irq_ack = 1'b0,
    output logic ret_done = 1'b0
);
    logic [2:0] cnt = 3'h0;
    // slow delays show the controller does not repeat the take meanwhile
    always @(posedge sys_clk) begin
        irq_ack <= !rst && cnt == 3'h1;
        ret_done <= !rst && ret_req;
        if (rst)
            cnt <= 3'h0;
        else if (irq_take)
            cnt <= {1'b0, ack_dly} + 3'h1;
        else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
    end
endmodule

// >>> tb/ipwc_tb.sv
// bench for the interrupt controller: register calls, events, pins, core stand-in
// assumes a 4 ns sys_clk and a free 40 ns slow oscillator
`timescale 1ns/100ps
module interrupt_priority_wakeup_ctrl_bench
    import ipwc_pkg::*;
;
    logic sys_clk = 0, rst = 1, reg_wr, reg_rd, osc_is_ext = 1, ls_clk_in = 0, ret_req, irq_ack, ret_done;
    logic core_run, irq_take;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port0_in, port1_in, fa, fb;
    logic [NSRC-1:0] src_event;
    logic [1:0] ack_dly;
    logic [15:0] irq_vector;
    logic [15:0] vt [15] = '{16'h0003, 16'h0083, 16'h0043, 16'h000B, 16'h008B, 16'h004B, 16'h0013,
        16'h0093, 16'h0053, 16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h002B, 16'h006B};
    int error_cnt = 0, n_checks = 0, cyc = 0;
    always #2 sys_clk = ~sys_clk;
    always #20 ls_clk_in = ~ls_clk_in;
    // short stop count keeps the run brief
    ipwc_top #(.EXT_HS_WAIT(16)) ipwc_top_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
        .port0_in(port0_in), .port1_in(port1_in), .osc_is_ext(osc_is_ext), .ls_clk_in(ls_clk_in),
        .core_run(core_run), .irq_ack(irq_ack), .ret_done(ret_done), .irq_take(irq_take), .irq_vector(irq_vector));
    ipwc_core_model ipwc_core_model_inst (.sys_clk(sys_clk), .rst(rst), .irq_take(irq_take), .ret_req(ret_req),
        .ack_dly(ack_dly), .irq_ack(irq_ack), .ret_done(ret_done));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // each call leaves a free cycle so no strobe is assigned twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge sys_clk);
    endtask
    task automatic ev(input logic [14:0] m);
        src_event <= m;
        @(posedge sys_clk);
        src_event <= '0;
        @(posedge sys_clk);
    endtask
    // look after the edge settles: a pulse launched on the entry edge is caught too
    task automatic take(input logic [15:0] v);
        #1;
        for (int k = 0; k < 30 && irq_take !== 1'b1; k++) @(posedge sys_clk) #1;
        chk(irq_take, 1'b1);
        chk(irq_vector, v);
        quiet(4);
        @(posedge sys_clk);
    endtask
    task automatic quiet(input int n);
        repeat (n) @(posedge sys_clk) #1 chk(irq_take, 1'b0);
    endtask
    task automatic ret;
        ret_req <= 1'b1;
        @(posedge sys_clk);
        ret_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic wake(input int lo, input int hi);
        int k;
        for (k = 0; k < 3000 && core_run !== 1'b1; k++) @(posedge sys_clk) #1;
        chk(k >= lo && k <= hi, 1'b1);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard well above the several hundred cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, src_event, port0_in, port1_in, ret_req, ack_dly} = '0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(OFS_P1_WAKE, 8'h00);
        rd(OFS_IRQ_EN0, 8'h00);
        wr(OFS_LVL_LO, 8'hFF);
        rd(OFS_LVL_LO, 8'h3F);
        wr(8'h00, 8'h5A);
        rd(8'h00, 8'h00);
        wr(OFS_LVL_LO, 8'h00);
        wr(OFS_IRQ_EN1, 8'h3F);
        wr(OFS_IRQ_EN2, 8'h0D);
        wr(OFS_IRQ_EN0, 8'h3F);
        ev(15'h0008);
        quiet(5);
        wr(OFS_FLAG_LO, 8'hFF);
        rd(OFS_FLAG_LO, 8'h08);
        wr(OFS_FLAG_LO, 8'hF7);
        rd(OFS_FLAG_LO, 8'h00);
        $display("test registers and flags done");
        wr(OFS_IRQ_EN0, 8'hBF);
        for (int i = 0; i < 15; i++) begin
            fa = i < 8 ? OFS_FLAG_LO : OFS_FLAG_HI;
            fb = 8'h01 << (i % 8);
            ev(15'h0001 << i);
            take(vt[i]);
            rd(fa, (i == 2 || i == 5 || i == 11) ? fb : 8'h00);
            wr(fa, ~fb);
            ret();
        end
        $display("test vectors done");
        ev(15'h0003);
        take(16'h0003);
        quiet(4);
        ret();
        take(16'h0083);
        ret();
        ack_dly <= 2'h2;
        wr(OFS_LVL_LO, 8'h20);
        wr(OFS_LVL_HI, 8'h20);
        ev(15'h4001);
        take(16'h006B);
        ret();
        take(16'h0003);
        ev(15'h2000);
        take(16'h002B);
        ev(15'h0008);
        quiet(4);
        ret();
        quiet(4);
        ret();
        take(16'h000B);
        ret();
        $display("test priority done");
        wr(OFS_PWR_CTRL, 8'h02);
        port1_in <= 8'h01;
        repeat (30) @(posedge sys_clk);
        chk(core_run, 1'b0);
        port0_in <= 8'h80;
        wake(56, 72);
        rd(OFS_PWR_CTRL, 8'h00);
        osc_is_ext <= 1'b0;
        wr(OFS_P1_WAKE, 8'h01);
        wr(OFS_PWR_CTRL, 8'h02);
        port1_in <= 8'h00;
        wake(104, 120);
        wr(OFS_PWR_CTRL, 8'h01);
        ev(15'h0008);
        take(16'h000B);
        chk(core_run, 1'b1);
        rd(OFS_PWR_CTRL, 8'h00);
        ret();
        $display("test wake done");
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(OFS_LVL_HI, 8'h00);
        $display("test second reset done");
        conclude();
    end
endmodule
bind ipwc_top ipwc_props ipwc_props_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_ack(irq_ack), .irq_take(irq_take), .irq_vector(irq_vector), .core_run(core_run));
